// File: bsk_params.svh
/*
 * Constants of the bit-set and bit-test-skip execution block: opcode patterns,
 * operand field positions, the no-operation word and instruction-cycle timing.
 * Assumes it is included by its bare name before the block's package.
 */
`ifndef BSK_PARAMS_SVH
`define BSK_PARAMS_SVH

`define BSK_WORD_W        14
`define BSK_OPC_HI        13
`define BSK_OPC_LO        10
`define BSK_BIT_HI        9
`define BSK_BIT_LO        7
`define BSK_REG_HI        6
`define BSK_REG_LO        0
`define BSK_OPC_BIT_SET   4'h5
`define BSK_OPC_BIT_TEST  4'h6
`define BSK_NOP_WORD      14'h0000
`define BSK_ADDR_RST      7'h00
`define BSK_BYTE_RST      8'h00
`define BSK_OSC_PER_INSTR 4
`define BSK_CLK_PERIOD_NS 100
`define BSK_OSC_PERIOD_NS 100
`define BSK_INSTR_CYCLES  ((`BSK_OSC_PER_INSTR * `BSK_OSC_PERIOD_NS) / `BSK_CLK_PERIOD_NS)

`endif

// File: bsk_pkg.sv
/*
 * Types shared by the bit-set and bit-test-skip execution block.
 * Assumes bsk_params.svh is on the include path.
 */
`include "bsk_params.svh"

package bsk_pkg;

   typedef enum logic [1:0] {
      BSK_Q1,
      BSK_Q2,
      BSK_Q3,
      BSK_Q4
   } bsk_phase_e;

   typedef struct packed {
      logic [6:0] addr;
      logic       wr;
      logic [7:0] wdata;
   } bsk_file_s;

endpackage : bsk_pkg

// File: bsk_phase.sv
/*
 * Phase sequencer: divides the clock into instruction cycles of four periods.
 * Assumes the clock is the oscillator and reset is shared with the core.
 */
`timescale 1ns/100ps
`default_nettype none

module bsk_phase
   import bsk_pkg::*;
(
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Current phase.
   output var  bsk_phase_e phase_q
);

   // Advances one phase each clock, wrapping after the fourth.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= BSK_Q1;
      end else begin
         case (phase_q)
            BSK_Q1:  phase_q <= BSK_Q2;
            BSK_Q2:  phase_q <= BSK_Q3;
            BSK_Q3:  phase_q <= BSK_Q4;
            default: phase_q <= BSK_Q1;
         endcase
      end
   end

endmodule : bsk_phase

`default_nettype wire

// File: bsk_exec.sv
/*
 * Execution of the bit-set and bit-test-skip-if-clear instructions.
 * Each instruction cycle is split into four phases: the register address is
 * latched at the end of the first, the whole byte is captured in the second, the new byte
 * and the skip decision are formed in the third, and in the fourth the byte is
 * written back while the next word is fetched.
 * Assumes program memory returns the fetched word combinationally while
 * fetch_q is high and that the file register array reads combinationally at
 * file_q.addr and writes at the clock edge ending a cycle with file_q.wr high.
 */
// Behaviour
// - A bit-set instruction forces the chosen bit of the addressed register to one and keeps all else.
// - A test instruction reads the chosen bit and skips the next instruction when it is zero, flags untouched.
// - When the tested bit is one the test takes one instruction cycle and the next instruction runs.
// - A skip replaces the prefetched word by a no-operation, so the test takes two cycles.
// - Both instructions take a seven-bit register address and a three-bit bit position.
// - Each instruction cycle is four oscillator periods, and single-cycle instructions end in one.
`timescale 1ns/100ps
`default_nettype none
`include "bsk_params.svh"

module bsk_exec
   import bsk_pkg::*;
(
   // Clock and reset.
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   // Program memory.
   input  wire logic [`BSK_WORD_W-1:0] pm_data,
   output logic                        fetch_q,
   // File register array.
   input  wire logic [7:0]             fr_rdata,
   output bsk_file_s                   file_q,
   // Execution status.
   output logic                        nop_exec_q,
   output logic                        instr_end_q
);

   // Phase of the instruction cycle and one flag for each phase.
   bsk_phase_e             phase;
   logic                   in_q1;
   logic                   in_q2;
   logic                   in_q3;
   logic                   in_q4;

   // Word in execution, its next value, its fields and its decoded operation.
   logic [`BSK_WORD_W-1:0] instr_q;
   logic [`BSK_WORD_W-1:0] instr_d;
   logic [3:0]             opc;
   logic [2:0]             bit_sel;
   logic [6:0]             reg_sel;
   logic                   is_set;
   logic                   is_test;

   // Chosen bit as a mask, the read byte with it set, and its old value.
   logic [7:0]             bit_mask;
   logic [7:0]             set_byte;
   logic [7:0]             bit_hit;
   logic                   bit_val;

   // Read-modify-write state, skip decision and next status.
   logic [6:0]             addr_q;
   logic [7:0]             rd_q;
   logic                   wr_q;
   logic [7:0]             wdata_q;
   logic                   skip_q;
   logic                   nop_exec_d;

   bsk_phase u_phase (
      .clock   (clock),
      .rst_n   (rst_n),
      .phase_q (phase)
   );

   // Flags the four phases of the instruction cycle.
   assign in_q1 = (phase == BSK_Q1);
   assign in_q2 = (phase == BSK_Q2);
   assign in_q3 = (phase == BSK_Q3);
   assign in_q4 = (phase == BSK_Q4);

   // Splits the word in execution into its fields.
   assign opc     = instr_q[`BSK_OPC_HI:`BSK_OPC_LO];
   assign bit_sel = instr_q[`BSK_BIT_HI:`BSK_BIT_LO];
   assign reg_sel = instr_q[`BSK_REG_HI:`BSK_REG_LO];

   // Decodes the two bit operations; any other opcode runs as a no-operation.
   always_comb begin
      is_set  = 1'b0;
      is_test = 1'b0;
      case (opc)
         `BSK_OPC_BIT_SET: begin
            is_set = 1'b1;
         end
         `BSK_OPC_BIT_TEST: begin
            is_test = 1'b1;
         end
         default: begin
            is_set  = 1'b0;
            is_test = 1'b0;
         end
      endcase
   end

   // Per bit: selects the chosen bit, sets it in the read byte and picks its value.
   for (genvar i = 0; i < 8; i++) begin : g_bit
      assign bit_mask[i] = (bit_sel == 3'(i));
      assign set_byte[i] = rd_q[i] | bit_mask[i];
      assign bit_hit[i]  = rd_q[i] & bit_mask[i];
   end
   assign bit_val = |bit_hit;

   // Latches the register address at the end of the first phase and drives it from the second.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= `BSK_ADDR_RST;
      end else if (in_q1) begin
         addr_q <= reg_sel;
      end
   end

   // Captures the whole addressed register in the second phase.
   // The write of a bit-set lands at the end of the fourth phase, before the
   // next capture, so a test in the following instruction sees the new bit.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= `BSK_BYTE_RST;
      end else if (in_q2) begin
         rd_q <= fr_rdata;
      end
   end

   // Raises the write strobe for the fourth phase of a bit-set only.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= 1'b0;
      end else if (in_q3) begin
         wr_q <= is_set;
      end else begin
         wr_q <= 1'b0;
      end
   end

   // Forms the modified byte at the end of the third phase.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wdata_q <= `BSK_BYTE_RST;
      end else if (in_q3) begin
         wdata_q <= set_byte;
      end
   end

   // Decides the skip from the tested bit; no flag is touched.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         skip_q <= 1'b0;
      end else if (in_q3) begin
         skip_q <= is_test && !bit_val;
      end
   end

   // Fetches the next word in the fourth phase.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fetch_q <= 1'b0;
      end else begin
         fetch_q <= in_q3;
      end
   end

   // Marks the last phase of every instruction cycle.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         instr_end_q <= 1'b0;
      end else begin
         instr_end_q <= in_q3;
      end
   end

   // Chooses the next word: the fetched one, or a no-operation on a skip.
   always_comb begin
      instr_d    = instr_q;
      nop_exec_d = nop_exec_q;
      if (in_q4) begin
         if (skip_q) begin
            instr_d    = `BSK_NOP_WORD;
            nop_exec_d = 1'b1;
         end else begin
            instr_d    = pm_data;
            nop_exec_d = 1'b0;
         end
      end
   end

   // Holds the word in execution.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         instr_q <= `BSK_NOP_WORD;
      end else begin
         instr_q <= instr_d;
      end
   end

   // Marks the cycle that runs a no-operation in place of a skipped word.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         nop_exec_q <= 1'b0;
      end else begin
         nop_exec_q <= nop_exec_d;
      end
   end

   // Presents address, strobe and byte to the file register array.
   assign file_q = '{addr: addr_q, wr: wr_q, wdata: wdata_q};

endmodule : bsk_exec

`default_nettype wire

// File: bsk_exec_properties.sv
/* Checker for the bit execution block, bound to bsk_exec.
   Assumes bsk_params.svh is on the include path. */
`timescale 1ns/100ps
`default_nettype none
`include "bsk_params.svh"
module bsk_exec_chk
   import bsk_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Memory sides.
   input wire logic [`BSK_WORD_W-1:0] pm_data,
   input wire logic fetch_q,
   input wire logic [7:0] fr_rdata,
   input wire bsk_file_s file_q,
   // Status.
   input wire logic nop_exec_q,
   input wire logic instr_end_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_per; fetch_q |=> !fetch_q [*3] ##1 fetch_q; endproperty
   a_per: assert property (p_per) else $error("bad cycle");
   property p_end; fetch_q == instr_end_q; endproperty
   a_end: assert property (p_end) else $error("bad end");
   property p_wrq4; file_q.wr |-> fetch_q; endproperty
   a_wrq4: assert property (p_wrq4) else $error("bad wr");
   property p_one; file_q.wr |-> $countones(file_q.wdata ^ fr_rdata) <= 1
      && (file_q.wdata & fr_rdata) == fr_rdata; endproperty
   a_one: assert property (p_one) else $error("bad wdata");
   property p_set; fetch_q && pm_data[13:10] == `BSK_OPC_BIT_SET |=> ##3 nop_exec_q
      || (file_q.wr && file_q.addr == $past(pm_data[6:0], 4)); endproperty
   a_set: assert property (p_set) else $error("bad set");
   property p_nowr; nop_exec_q |-> !file_q.wr; endproperty
   a_nowr: assert property (p_nowr) else $error("wr in nop");
   property p_nop4; $rose(nop_exec_q) |-> nop_exec_q [*4] ##1 !nop_exec_q; endproperty
   a_nop4: assert property (p_nop4) else $error("bad nop");
   property p_cause; $rose(nop_exec_q) |-> $past(fetch_q, 5)
      && $past(pm_data[13:10], 5) == `BSK_OPC_BIT_TEST; endproperty
   a_cause: assert property (p_cause) else $error("bad skip");
endmodule : bsk_exec_chk
bind bsk_exec bsk_exec_chk u_chk (.clock(clock), .rst_n(rst_n), .pm_data(pm_data),
   .fetch_q(fetch_q), .fr_rdata(fr_rdata), .file_q(file_q), .nop_exec_q(nop_exec_q),
   .instr_end_q(instr_end_q));
`default_nettype wire

// File: bsk_mem_model.sv
/* Program memory and file array model.
   Assumes the bench loads prog and mem. */
`timescale 1ns/100ps
`default_nettype none
module bsk_mem_model
   import bsk_pkg::*;
(
   // Clock.
   input wire logic clock,
   // Memory sides.
   input wire logic fetch_q,
   output logic [13:0] pm_data,
   input wire bsk_file_s file_q,
   output logic [7:0] fr_rdata
);
   logic [13:0] prog [0:15] = '{default: 14'h0000};
   logic [7:0] mem [0:127] = '{default: 8'h00};
   logic [3:0] pc = 4'h0;
   assign pm_data = fetch_q ? prog[pc] : ~prog[pc];
   assign fr_rdata = mem[file_q.addr];
   always @(posedge clock) begin
      if (fetch_q === 1'b1) pc <= pc + 4'h1;
      if (file_q.wr === 1'b1) mem[file_q.addr] <= file_q.wdata;
   end
endmodule : bsk_mem_model
`default_nettype wire

// File: bsk_exec_tb.sv
/* Bench for bsk_exec with the memory model.
   Assumes the checker is bound to the design. */
`timescale 1ns/100ps
`default_nettype none
module bsk_exec_tb;
   import bsk_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [13:0] pm_data;
   logic [7:0] fr_rdata;
   logic fetch_q;
   logic nop_exec_q;
   bsk_file_s file_q;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   int nops = 0;
   bsk_exec dut (.clock(clock), .rst_n(rst_n), .pm_data(pm_data), .fetch_q(fetch_q),
      .fr_rdata(fr_rdata), .file_q(file_q), .nop_exec_q(nop_exec_q), .instr_end_q());
   bsk_mem_model u_mem (.clock(clock), .fetch_q(fetch_q), .pm_data(pm_data),
      .file_q(file_q), .fr_rdata(fr_rdata));
   initial forever #50 clock = ~clock;
   task give_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (nop_exec_q === 1'b1) nops <= nops + 1;
      if (cyc == 2000) begin
         error_cnt++;
         give_verdict();
      end
   end
   // Set bit 7 of register 127, test it, then set bit 0 of register 1.
   task t_set_test();
      u_mem.mem[127] <= 8'h0a;
      u_mem.prog[0]  <= 14'h17ff;
      u_mem.prog[1]  <= 14'h1bff;
      u_mem.prog[2]  <= 14'h1401;
      repeat (24) @(posedge clock);
      check("reg127", u_mem.mem[127], 8'h0a | 8'h80);
      check("reg1", u_mem.mem[1], 8'h01);
      check("nops", 8'(nops), 8'h00);
   endtask : t_set_test
   // Test a clear bit; the following bit-set must be dropped.
   task t_skip();
      u_mem.mem[0]  <= 8'hfe;
      u_mem.prog[7] <= 14'h1800;
      u_mem.prog[8] <= 14'h1482;
      u_mem.prog[9] <= 14'h1502;
      repeat (24) @(posedge clock);
      check("reg2", u_mem.mem[2], 8'h04);
      check("reg0", u_mem.mem[0], 8'hfe);
      check("nops", 8'(nops), 8'h04);
   endtask : t_skip
   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      t_set_test();
      t_skip();
      give_verdict();
   end
endmodule : bsk_exec_tb
`default_nettype wire
